// >>> logic/dup_pkg.sv
package dup_pkg;
    // Register offsets on the plain register port, one set per channel
    localparam logic [3:0] DUP_OFF_THR = 4'h0;
    localparam logic [3:0] DUP_OFF_RHR = 4'h1;
    localparam logic [3:0] DUP_OFF_IER = 4'h2;
    localparam logic [3:0] DUP_OFF_MCR = 4'h3;
    localparam logic [3:0] DUP_OFF_EFR = 4'h4;
    localparam logic [3:0] DUP_OFF_DLD = 4'h5;
    localparam logic [3:0] DUP_OFF_MSR = 4'h6;
    localparam logic [3:0] DUP_OFF_DIV = 4'h7;
    localparam logic [3:0] DUP_OFF_LSR = 4'h8;
    localparam int DUP_CHAN_BIT = 4;
    // Field positions
    localparam int DUP_MCR_DTR = 0;
    localparam int DUP_MCR_RTS = 1;
    localparam int DUP_MCR_OP2 = 3;
    localparam int DUP_MCR_IRDA = 6;
    localparam int DUP_MCR_RXINV = 7;
    localparam int DUP_EFR_ARTS = 6;
    localparam int DUP_EFR_ACTS = 7;
    localparam int DUP_IER_ARTS = 6;
    localparam int DUP_IER_ACTS = 7;
    localparam int DUP_DLD_485 = 6;
    // Reset values
    localparam logic [7:0] DUP_RST_REG = 8'h00;
    localparam logic [15:0] DUP_RST_DIV = 16'h0010;
    // Bit time in clocks = divisor * 16; IR pulse is 3/16 of a bit
    localparam int DUP_OVERSAMPLE = 16;
    localparam int DUP_IR_PULSE = 3;
    localparam int DUP_FIFO_DEPTH = 16;
    localparam int DUP_FIFO_WIDTH = 8;
    localparam logic [4:0] DUP_FIFO_HIGH = 5'h0e;
    typedef enum logic [1:0] {
        DUP_TX_IDLE = 2'b00,
        DUP_TX_SHIFT = 2'b01,
        DUP_TX_HOLD = 2'b10
    } dup_tx_state_t;
endpackage

// >>> logic/dup_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module dup_fifo import dup_pkg::*; #(
    parameter int WIDTH = DUP_FIFO_WIDTH,
    parameter int DEPTH = DUP_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } dup_fifo_st_t;
    dup_fifo_st_t s_q, s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push, pop;
    assign level_o = s_q.wr - s_q.rd;
    assign in_ready_o = level_o != (AW+1)'(DEPTH);
    assign out_valid_o = s_q.wr != s_q.rd;
    assign out_data_o = mem_q[s_q.rd[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // Storage is not reset: only the pointers say what is valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[s_q.wr[AW-1:0]] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// >>> logic/dup_chan.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dup_chan import dup_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic serial_in_i,
    input wire logic clear_send_n_i,
    input wire logic set_ready_n_i,
    input wire logic carrier_detect_n_i,
    input wire logic ring_indicator_n_i,
    output logic serial_out_o,
    output logic request_send_n_o,
    output logic terminal_ready_n_o,
    output logic output_port2_n_o,
    output logic irq_out_o,
    output logic irq_out_oe_n_o
);
    typedef struct packed {
        logic [7:0] interrupt_enable_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic [7:0] divisor_fraction_reg;
        logic [15:0] div;
        dup_tx_state_t st;
        logic [8:0] shreg;
        logic [3:0] nbits;
        logic [19:0] tick;
        logic txd;
        logic rts_n;
        logic dtr_n;
        logic op2_n;
        logic irq;
        logic irq_oe_n;
        logic [7:0] rdata;
        logic [3:0] msr_n;
        logic rx_samp;
    } dup_chan_st_t;
    dup_chan_st_t s_q, s_d;
    logic [7:0] f_data;
    logic f_valid, f_ready, f_pop;
    logic [4:0] f_level;
    logic wr_thr, rx_to_decoder, cts_block, irda;
    function automatic logic [19:0] bit_clocks(input logic [15:0] div);
        bit_clocks = {div, 4'h0};
    endfunction
    assign wr_thr = wr_i && addr_i == DUP_OFF_THR;
    assign irda = s_q.modem_control_reg[DUP_MCR_IRDA];
    // In infrared mode, MCR bit 7 inverts the receive input to the decoder
    assign rx_to_decoder = irda ? (s_q.rx_samp ^ s_q.modem_control_reg[DUP_MCR_RXINV]) : s_q.rx_samp;
    assign cts_block = s_q.enhanced_feature_reg[DUP_EFR_ACTS] && s_q.interrupt_enable_reg[DUP_IER_ACTS] && clear_send_n_i;
    assign f_pop = s_q.st == DUP_TX_IDLE && f_valid && !cts_block;
    dup_fifo #(.WIDTH(DUP_FIFO_WIDTH), .DEPTH(DUP_FIFO_DEPTH)) u_txfifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(wdata_i),
        .in_valid_i(wr_thr),
        .in_ready_o(f_ready),
        .out_data_o(f_data),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop),
        .level_o(f_level)
    );
    always_comb begin
        logic lvl;
        lvl = 1'b0;
        s_d = s_q;
        s_d.rx_samp = serial_in_i;
        s_d.msr_n = {carrier_detect_n_i, ring_indicator_n_i, set_ready_n_i, clear_send_n_i};
        if (wr_i) begin
            case (addr_i)
                DUP_OFF_IER: s_d.interrupt_enable_reg = wdata_i;
                DUP_OFF_MCR: s_d.modem_control_reg = wdata_i;
                DUP_OFF_EFR: s_d.enhanced_feature_reg = wdata_i;
                DUP_OFF_DLD: s_d.divisor_fraction_reg = wdata_i;
                DUP_OFF_DIV: s_d.div = {wdata_i, s_q.div[7:0]};
                default: ;
            endcase
        end
        s_d.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                DUP_OFF_RHR: s_d.rdata = {7'h00, rx_to_decoder};
                DUP_OFF_IER: s_d.rdata = s_q.interrupt_enable_reg;
                DUP_OFF_MCR: s_d.rdata = s_q.modem_control_reg;
                DUP_OFF_EFR: s_d.rdata = s_q.enhanced_feature_reg;
                DUP_OFF_DLD: s_d.rdata = s_q.divisor_fraction_reg;
                DUP_OFF_MSR: s_d.rdata = {4'h0, ~s_q.msr_n};
                DUP_OFF_DIV: s_d.rdata = s_q.div[15:8];
                DUP_OFF_LSR: s_d.rdata = {f_ready, s_q.st == DUP_TX_IDLE, 1'b0, f_level};
                default: s_d.rdata = 8'h00;
            endcase
        end
        case (s_q.st)
            DUP_TX_IDLE: begin
                if (f_pop) begin
                    s_d.shreg = {f_data, 1'b0};
                    s_d.nbits = 4'h9;
                    s_d.tick = bit_clocks(s_q.div) - 20'h00001;
                    s_d.st = DUP_TX_SHIFT;
                end
            end
            DUP_TX_SHIFT: begin
                if (s_q.tick == 20'h00000) begin
                    s_d.tick = bit_clocks(s_q.div) - 20'h00001;
                    s_d.shreg = {1'b1, s_q.shreg[8:1]};
                    s_d.nbits = s_q.nbits - 4'h1;
                    if (s_q.nbits == 4'h0) begin
                        s_d.st = DUP_TX_HOLD;
                    end
                end else begin
                    s_d.tick = s_q.tick - 20'h00001;
                end
            end
            DUP_TX_HOLD: begin
                // One idle bit after stop keeps 485 direction held through stop bit
                if (s_q.tick == 20'h00000) begin
                    s_d.st = DUP_TX_IDLE;
                end else begin
                    s_d.tick = s_q.tick - 20'h00001;
                end
            end
            default: s_d.st = DUP_TX_IDLE;
        endcase
        // Line level for the bit in flight: start bit sits below the data, so the LSB is always the bit
        if (s_d.st == DUP_TX_SHIFT) begin
            lvl = s_d.shreg[0];
            if (irda) begin
                // Pulse for a zero bit only; rests low otherwise
                s_d.txd = !lvl && s_d.tick >= bit_clocks(s_q.div) - 20'(DUP_IR_PULSE) * {4'h0, s_q.div};
            end else begin
                s_d.txd = lvl;
            end
        end else begin
            s_d.txd = !irda;
        end
        if (s_q.divisor_fraction_reg[DUP_DLD_485]) begin
            s_d.rts_n = s_d.st == DUP_TX_IDLE;
        end else if (s_q.enhanced_feature_reg[DUP_EFR_ARTS] && s_q.interrupt_enable_reg[DUP_IER_ARTS]) begin
            // Software has already asserted request first; deassert near full
            s_d.rts_n = !s_q.modem_control_reg[DUP_MCR_RTS] || f_level >= DUP_FIFO_HIGH;
        end else begin
            s_d.rts_n = !s_q.modem_control_reg[DUP_MCR_RTS];
        end
        s_d.dtr_n = !s_q.modem_control_reg[DUP_MCR_DTR];
        s_d.op2_n = !s_q.modem_control_reg[DUP_MCR_OP2];
        s_d.irq_oe_n = !s_q.modem_control_reg[DUP_MCR_OP2];
        s_d.irq = f_valid == 1'b0 && (s_q.interrupt_enable_reg[0] || s_q.interrupt_enable_reg[1]);
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.div <= DUP_RST_DIV;
            s_q.st <= DUP_TX_IDLE;
            s_q.txd <= 1'b1;
            s_q.rts_n <= 1'b1;
            s_q.dtr_n <= 1'b1;
            s_q.op2_n <= 1'b1;
            s_q.irq_oe_n <= 1'b1;
            s_q.msr_n <= 4'hf;
            s_q.rx_samp <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    assign rdata_o = s_q.rdata;
    assign serial_out_o = s_q.txd;
    assign request_send_n_o = s_q.rts_n;
    assign terminal_ready_n_o = s_q.dtr_n;
    assign output_port2_n_o = s_q.op2_n;
    assign irq_out_o = s_q.irq;
    assign irq_out_oe_n_o = s_q.irq_oe_n;
endmodule
`default_nettype wire

// >>> logic/dup_top.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Standard mode: transmit idles and resets high
// - Infrared mode: encoder output rests low
// - Software inversion of infrared receive polarity
// - Request pin doubles as 485 direction
// - Clear-to-send gates transmit under auto flow
// - Bit3 set: irq driven, port2 low
// - Bit3 clear: irq floats, port2 high
// - Modem pins usable as general I/O
module dup_top import dup_pkg::*; (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [4:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic SERIAL_IN_CHAN_A_I,
    input wire logic SERIAL_IN_CHAN_B_I,
    input wire logic [1:0] CLEAR_SEND_N_I,
    input wire logic [1:0] SET_READY_N_I,
    input wire logic [1:0] CARRIER_DETECT_N_I,
    input wire logic [1:0] RING_INDICATOR_N_I,
    output logic SERIAL_OUT_CHAN_A_O,
    output logic SERIAL_OUT_CHAN_B_O,
    output logic [1:0] REQUEST_SEND_N_O,
    output logic [1:0] TERMINAL_READY_N_O,
    output logic [1:0] OUTPUT_PORT2_N_O,
    output logic [1:0] IRQ_OUT_O,
    output logic [1:0] IRQ_OUT_OE_N_O
);
    // ==========================================
    // Channels
    logic [7:0] rdata [2];
    logic [1:0] sin, sout;
    logic rd_b_q;
    assign sin = {SERIAL_IN_CHAN_B_I, SERIAL_IN_CHAN_A_I};
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic sel;
        assign sel = ADDR_I[DUP_CHAN_BIT] == 1'(c);
        dup_chan u_chan (
            .clk_i(MCLK_I),
            .rst_i(RST_I),
            .addr_i(ADDR_I[3:0]),
            .wdata_i(WDATA_I),
            .wr_i(WR_I && sel),
            .rd_i(RD_I && sel),
            .rdata_o(rdata[c]),
            .serial_in_i(sin[c]),
            .clear_send_n_i(CLEAR_SEND_N_I[c]),
            .set_ready_n_i(SET_READY_N_I[c]),
            .carrier_detect_n_i(CARRIER_DETECT_N_I[c]),
            .ring_indicator_n_i(RING_INDICATOR_N_I[c]),
            .serial_out_o(sout[c]),
            .request_send_n_o(REQUEST_SEND_N_O[c]),
            .terminal_ready_n_o(TERMINAL_READY_N_O[c]),
            .output_port2_n_o(OUTPUT_PORT2_N_O[c]),
            .irq_out_o(IRQ_OUT_O[c]),
            .irq_out_oe_n_o(IRQ_OUT_OE_N_O[c])
        );
    end
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_b_q <= 1'b0;
        end else begin
            rd_b_q <= ADDR_I[DUP_CHAN_BIT];
        end
    end
    // Each channel's read data is already a register and is zero unless it was read
    assign RDATA_O = rd_b_q ? rdata[1] : rdata[0];
    assign SERIAL_OUT_CHAN_A_O = sout[0];
    assign SERIAL_OUT_CHAN_B_O = sout[1];
endmodule
`default_nettype wire

// >>> verif/dup_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dup_top_monitor import dup_pkg::*; (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [4:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic SERIAL_IN_CHAN_A_I,
    input wire logic [1:0] CLEAR_SEND_N_I,
    input wire logic [1:0] SET_READY_N_I,
    input wire logic [1:0] CARRIER_DETECT_N_I,
    input wire logic [1:0] RING_INDICATOR_N_I,
    input wire logic SERIAL_OUT_CHAN_A_O,
    input wire logic SERIAL_OUT_CHAN_B_O,
    input wire logic [1:0] REQUEST_SEND_N_O,
    input wire logic [1:0] TERMINAL_READY_N_O,
    input wire logic [1:0] OUTPUT_PORT2_N_O,
    input wire logic [1:0] IRQ_OUT_OE_N_O
);
    // Longer than a full FIFO drains after the last channel A write or clear change, so the line is at rest
    localparam logic [15:0] QUIET = 16'hb798;
    logic [7:0] mcr_q;
    logic [15:0] quiet_q;
    logic cts_q;
    wire logic wmcr = WR_I && ADDR_I == {1'b0, DUP_OFF_MCR};
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            mcr_q <= 8'h00;
            quiet_q <= 16'h0000;
            cts_q <= 1'b1;
        end else begin
            cts_q <= CLEAR_SEND_N_I[0];
            if (wmcr)
                mcr_q <= WDATA_I;
            if ((WR_I && !ADDR_I[DUP_CHAN_BIT]) || CLEAR_SEND_N_I[0] != cts_q)
                quiet_q <= 16'h0000;
            else if (quiet_q != QUIET)
                quiet_q <= quiet_q + 16'h0001;
        end
    end
    // =====
    // Checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    property p_reset_idle;
        $fell(RST_I) |-> SERIAL_OUT_CHAN_A_O && SERIAL_OUT_CHAN_B_O && (&REQUEST_SEND_N_O) && (&IRQ_OUT_OE_N_O);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("line not idle after reset");
    property p_op2_a;
        wmcr |-> ##2 OUTPUT_PORT2_N_O[0] == !$past(WDATA_I[DUP_MCR_OP2], 2);
    endproperty
    a_op2_a: assert property (p_op2_a) else $error("port2 A wrong");
    property p_op2_b;
        WR_I && ADDR_I == {1'b1, DUP_OFF_MCR} |-> ##2 OUTPUT_PORT2_N_O[1] == !$past(WDATA_I[DUP_MCR_OP2], 2);
    endproperty
    a_op2_b: assert property (p_op2_b) else $error("port2 B wrong");
    property p_oe;
        IRQ_OUT_OE_N_O == OUTPUT_PORT2_N_O;
    endproperty
    a_oe: assert property (p_oe) else $error("irq drive and port2 disagree");
    property p_dtr_a;
        wmcr |-> ##2 TERMINAL_READY_N_O[0] == !$past(WDATA_I[DUP_MCR_DTR], 2);
    endproperty
    a_dtr_a: assert property (p_dtr_a) else $error("terminal ready A wrong");
    property p_rd_idle;
        !$past(RD_I) |-> RDATA_O == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_msr_a;
        RD_I && ADDR_I == {1'b0, DUP_OFF_MSR} |=> RDATA_O[3:0] == ~{$past(CARRIER_DETECT_N_I[0], 2),
            $past(RING_INDICATOR_N_I[0], 2), $past(SET_READY_N_I[0], 2), $past(CLEAR_SEND_N_I[0], 2)};
    endproperty
    a_msr_a: assert property (p_msr_a) else $error("modem status A wrong");
    property p_rhr_a;
        RD_I && ADDR_I == {1'b0, DUP_OFF_RHR} |=> RDATA_O[0] == ($past(SERIAL_IN_CHAN_A_I, 2) ^ (&$past(mcr_q[7:6])));
    endproperty
    a_rhr_a: assert property (p_rhr_a) else $error("receive polarity A wrong");
    property p_idle_a;
        quiet_q == QUIET |-> SERIAL_OUT_CHAN_A_O == !mcr_q[DUP_MCR_IRDA];
    endproperty
    a_idle_a: assert property (p_idle_a) else $error("transmit A not at rest level");
    c_quiet: cover property (quiet_q == QUIET);
    c_msr: cover property (RD_I && ADDR_I == {1'b0, DUP_OFF_MSR});
    c_dir: cover property (!REQUEST_SEND_N_O[0] && !SERIAL_OUT_CHAN_A_O);
endmodule
bind dup_top dup_top_monitor dup_top_monitor_i (.MCLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .SERIAL_IN_CHAN_A_I, .CLEAR_SEND_N_I, .SET_READY_N_I, .CARRIER_DETECT_N_I, .RING_INDICATOR_N_I,
    .SERIAL_OUT_CHAN_A_O, .SERIAL_OUT_CHAN_B_O, .REQUEST_SEND_N_O, .TERMINAL_READY_N_O, .OUTPUT_PORT2_N_O,
    .IRQ_OUT_OE_N_O);
`default_nettype wire

// >>> verif/dup_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module dup_line_model #(
    parameter int BIT = 256
) (
    input wire logic clk_i,
    input wire logic tx_i,
    input wire logic rx_lvl_i,
    output logic rx_o,
    output logic [7:0] byte_o,
    output logic got_o
);
    assign rx_o = rx_lvl_i;
    // A frame whose stop bit is low is dropped, so the bench sees a missing byte
    initial begin
        got_o = 1'b0;
        byte_o = 8'h00;
        forever begin
            @(negedge tx_i);
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                byte_o[i] = tx_i;
            end
            repeat (BIT) @(posedge clk_i);
            got_o <= tx_i;
            @(posedge clk_i);
            got_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top import dup_pkg::*;;
    logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, watch = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, m, d, v;
    logic [1:0] cts_n = 2'b00, dsr_n = 2'b11, cd_n = 2'b11, ri_n = 2'b11, rx_lvl = 2'b11;
    wire logic [7:0] rdata, byte_a, byte_b;
    wire logic rx_a, rx_b, tx_a, tx_b, got_a, got_b;
    wire logic [1:0] rts_n, dtr_n, op2_n, irq, oe_n;
    int error_cnt = 0, cmp_count = 0, n, k;
    int q_a[$], q_b[$];
    dup_top dup_top_i (.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .SERIAL_IN_CHAN_A_I(rx_a), .SERIAL_IN_CHAN_B_I(rx_b), .CLEAR_SEND_N_I(cts_n),
        .SET_READY_N_I(dsr_n), .CARRIER_DETECT_N_I(cd_n), .RING_INDICATOR_N_I(ri_n), .SERIAL_OUT_CHAN_A_O(tx_a),
        .SERIAL_OUT_CHAN_B_O(tx_b), .REQUEST_SEND_N_O(rts_n), .TERMINAL_READY_N_O(dtr_n),
        .OUTPUT_PORT2_N_O(op2_n), .IRQ_OUT_O(irq), .IRQ_OUT_OE_N_O(oe_n));
    dup_line_model line_a (.clk_i(mclk), .tx_i(tx_a), .rx_lvl_i(rx_lvl[0]), .rx_o(rx_a), .byte_o(byte_a), .got_o(got_a));
    dup_line_model line_b (.clk_i(mclk), .tx_i(tx_b), .rx_lvl_i(rx_lvl[1]), .rx_o(rx_b), .byte_o(byte_b), .got_o(got_b));
    initial forever #2 mclk = ~mclk;
    // =====
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Strobe low for one edge after each access keeps one assignment per time step
    task automatic wreg(input logic [4:0] a, input logic [7:0] dv);
        addr <= a;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rreg(input logic [4:0] a, output logic [7:0] r);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 r = rdata;
        @(posedge mclk);
    endtask
    task automatic drain();
        for (n = 0; n < 60000 && q_a.size() + q_b.size() > 0; n++)
            @(posedge mclk);
        check(q_a.size() + q_b.size(), 8'h00);
    endtask
    always @(posedge mclk) begin
        // Mode toggling in the pin scenarios leaves stray frames on the lines, so frames count once bytes flow
        if (watch && got_a === 1'b1)
            check(byte_a, q_a.pop_front());
        if (watch && got_b === 1'b1)
            check(byte_b, q_b.pop_front());
    end
    initial begin
        #360us;
        error_cnt++;
        print_verdict();
    end
    // =====
    // Scenarios
    initial begin
        n = $urandom(32'ha810);
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 check({tx_a, tx_b, op2_n, oe_n}, 8'h3f);
        check(irq, 2'b00);
        for (k = 2; k < 32; k++)
            if (k[3:0] != 1 && k[3:0] != 6 && k[3:0] != 8) begin
                rreg(5'(k), v);
                check(v, 8'h00);
            end
        for (int i = 0; i < 8; i++) begin
            m = 8'($urandom);
            d = 8'($urandom);
            {cts_n, dsr_n, cd_n, ri_n} <= 8'($urandom);
            rx_lvl <= 2'($urandom);
            wreg(5'h03, m);
            wreg(5'h13, d);
            #1 check({op2_n, oe_n}, {~d[3], ~m[3], ~d[3], ~m[3]});
            check({dtr_n, rts_n}, {~d[0], ~m[0], ~d[1], ~m[1]});
            rreg(5'h01, v);
            check(v[0], rx_lvl[0] ^ (m[6] & m[7]));
            rreg(5'h11, v);
            check(v[0], rx_lvl[1] ^ (d[6] & d[7]));
            rreg(5'h16, v);
            check(v, {4'h0, ~cd_n[1], ~ri_n[1], ~dsr_n[1], ~cts_n[1]});
            rreg(5'h06, v);
            check(v, {4'h0, ~cd_n[0], ~ri_n[0], ~dsr_n[0], ~cts_n[0]});
        end
        cts_n <= 2'b00;
        rx_lvl <= 2'b11;
        wreg(5'h03, 8'h00);
        wreg(5'h13, 8'h00);
        repeat (3000) @(posedge mclk);
        watch = 1'b1;
        for (int i = 0; i < 3; i++) begin
            m = 8'($urandom);
            wreg(5'h00, m);
            q_a.push_back(m);
            wreg(5'h10, ~m);
            q_b.push_back(~m);
        end
        drain();
        wreg(5'h05, 8'h40);
        wreg(5'h00, 8'h5a);
        q_a.push_back(8'h5a);
        for (n = 0; n < 1000 && tx_a !== 1'b0; n++)
            @(posedge mclk);
        #1 check(rts_n[0], 1'b0);
        drain();
        repeat (600) @(posedge mclk);
        #1 check(rts_n[0], 1'b1);
        wreg(5'h05, 8'h00);
        wreg(5'h03, 8'h02);
        wreg(5'h04, 8'hc0);
        wreg(5'h02, 8'hc0);
        cts_n <= 2'b01;
        for (int i = 0; i < 17; i++) begin
            rreg(5'h08, v);
            check(v[7], i < DUP_FIFO_DEPTH);
            check(v[4:0], i);
            #1 check(rts_n[0], i >= DUP_FIFO_HIGH);
            m = 8'($urandom);
            wreg(5'h00, m);
            if (i < DUP_FIFO_DEPTH)
                q_a.push_back(m);
        end
        repeat (600) @(posedge mclk);
        #1 check(tx_a, 1'b1);
        cts_n <= 2'b00;
        drain();
        #1 check(rts_n[0], 1'b0);
        wreg(5'h13, 8'h40);
        #1 check(tx_b, 1'b0);
        wreg(5'h10, 8'h00);
        k = 0;
        repeat (3500) begin
            @(posedge mclk);
            k += (tx_b === 1'b1);
        end
        check(k == 9 * DUP_IR_PULSE * DUP_OVERSAMPLE, 1'b1);
        check(tx_b, 1'b0);
        // Interrupt use on B: port2 is set once and then left alone
        wreg(5'h13, 8'h48);
        wreg(5'h12, 8'h01);
        #1 check({irq, oe_n}, 4'b1001);
        print_verdict();
    end
endmodule
`default_nettype wire
